// >>> pkg/pfc_pkg.sv
/*
 Shared constants and carriers for the partial frame fetch controller:
 register byte offsets, control field positions, reset values and the
 packed structs that travel between the controller and its neighbours.
 Assumes a 32-bit register port with byte-addressed, word-aligned offsets.
*/
package pfc_pkg;

   localparam int unsigned LINE_W = 16;
   localparam int unsigned ADDR_W = 12;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_PUSH = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_VMIN = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_VMAX = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_FLIPLINE = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_WINDOW = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_SRC_SIZE = 12'h01c;
   localparam logic [ADDR_W-1:0] OFS_VBLANK_START = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_VACTIVE = 12'h024;
   localparam logic [ADDR_W-1:0] OFS_SLICE_ROWS = 12'h028;
   localparam logic [ADDR_W-1:0] OFS_REGION = 12'h02c;
   // plane/pointer register window: bit 8 set selects it
   localparam int unsigned PLANE_WIN_BIT = 8;

   // control field positions
   localparam int unsigned CTRL_VRR_EN = 0;
   localparam int unsigned CTRL_PARTIAL_EN = 1;
   localparam int unsigned CTRL_MANUAL_TRACK = 2;
   localparam int unsigned CTRL_REDUCED_FETCH = 3;
   localparam int unsigned CTRL_CHIP_ON_GLASS = 4;
   localparam int unsigned CTRL_FULL_SINGLE = 5;
   localparam int unsigned CTRL_FULL_CONT = 6;
   localparam int unsigned CTRL_BUFFERED_VERTICAL_ACTIVE = 7;
   localparam int unsigned CTRL_W = 8;

   localparam int unsigned PUSH_ENABLE = 0;
   localparam int unsigned PUSH_SEND = 1;

   localparam int unsigned STAT_PUSH_DONE = 0;
   localparam int unsigned STAT_REDUCED = 1;
   localparam int unsigned STAT_PARTIAL_OK = 2;
   localparam int unsigned STAT_BANK = 3;

   // reset values
   localparam logic [LINE_W-1:0] RST_VMIN = 16'h0438;
   localparam logic [LINE_W-1:0] RST_VMAX = 16'h0898;
   localparam logic [LINE_W-1:0] RST_FLIPLINE = 16'h0439;
   localparam logic [LINE_W-1:0] RST_VBLANK_START = 16'h0438;
   localparam logic [LINE_W-1:0] RST_ONE = 16'h0001;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [LINE_W-1:0] first_line;
      logic [LINE_W-1:0] last_line;
   } pfc_region_t;

   typedef struct packed {
      logic [LINE_W-1:0] src_size;
      logic [LINE_W-1:0] slice_rows;
      logic [LINE_W-1:0] vblank_start;
      logic [LINE_W-1:0] vactive;
   } pfc_timing_t;

endpackage

// >>> rtl/pfc_regmem.sv
/*
 Small synchronous memory for the plane and pointer register sets.
 One write port and one read port; read data come out of a register one
 cycle after the read address. Assumes a single clock.
*/
`timescale 1ns/1ps
module pfc_regmem #(
   parameter int unsigned AW = 6,
   parameter int unsigned DW = 32
)(
   // clock
   input wire logic i_clock,
   // write port
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   // read port
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem_ff [2**AW];
   logic [DW-1:0] rdata_ff;

   always_ff @(posedge i_clock)
   begin
      if (i_we)
      begin
         mem_ff[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clock)
   begin
      rdata_ff <= mem_ff[i_raddr];
   end

   assign o_rdata = rdata_ff;
endmodule

// >>> rtl/pfc_top.sv
/*
 Partial frame fetch controller: variable refresh vertical timing with a
 delayed-vblank guard window, asynchronous partial update sequencing with
 a region metadata packet, double-buffered timing shadows and per-frame
 selection between regular and reduced-fetch plane/pointer register sets.
 Assumes line tick from the pixel pipe on the same clock, and a register
 port whose read data are taken the cycle after the read strobe.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - guard window excluded from decisions; inserted before delayed vblank, pushes vblank out.
// - one region per frame; needs manual tracking and reduced fetch; no chip-on-glass.
// - region metadata packet goes out before the frame's active pixels.
// - source size, slice rows latch at vblank; vblank start, vactive at vtotal.
// - regions never merged; last programmed region before update is used.
// - separate reduced-fetch set; chosen per frame automatically.
// - reduced-fetch set double-buffered, armed with regular set.
module pfc_top
   import pfc_pkg::*;
#(
   parameter int unsigned PLANES = 4,
   parameter int unsigned REGS_PER_PLANE = 4
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // register port
   input wire logic [pfc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // pixel pipe timing
   input wire logic i_line_tick,
   // plane fetch read port
   input wire logic [7:0] i_fetch_idx,
   output logic [31:0] o_fetch_data,
   // frame outputs
   output logic o_vblank,
   output logic o_first_line,
   output logic o_meta_valid,
   output pfc_pkg::pfc_region_t o_meta_region,
   output logic o_active_en,
   output logic o_reduced_frame,
   output pfc_pkg::pfc_timing_t o_timing
);
   import pfc_pkg::*;

   localparam int unsigned SET_ENTRIES = PLANES * REGS_PER_PLANE;
   localparam int unsigned IDX_W = $clog2(SET_ENTRIES);
   localparam int unsigned MEM_AW = IDX_W + 2;

   // write index comes from address bits 6:2, so at most 32 entries per set
   if (IDX_W < 1 || IDX_W > 5)
   begin
      $error("pfc_top: plane register set size unsupported");
   end

   // address of an entry: bank, set (1 = reduced fetch), index
   function automatic logic [MEM_AW-1:0] ent_addr(input logic bank, input logic red,
                                                  input logic [7:0] idx);
      ent_addr = {bank, red, idx[IDX_W-1:0]};
   endfunction

   logic [CTRL_W-1:0] ctrl_ff;
   logic push_en_ff, send_push_ff, push_done_ff;
   logic [LINE_W-1:0] vmin_ff, vmax_ff, flip_ff, window_ff;
   pfc_timing_t pend_ff, live_ff;
   pfc_region_t region_ff, frame_region_ff;
   logic [LINE_W-1:0] line_ff, guard_ff;
   logic guard_on_ff, vblank_ff, reduced_ff, bank_ff;
   logic meta_ff, active_ff, meta_due_ff, first_ff;
   logic [31:0] rdata_ff;
   logic frame_end, decision, update_now, partial_ok, want_reduced;
   logic plane_wr;

   assign plane_wr = i_wr && i_addr[PLANE_WIN_BIT];

   // partial update only under manual tracking and reduced fetch
   assign partial_ok = ctrl_ff[CTRL_PARTIAL_EN] && ctrl_ff[CTRL_MANUAL_TRACK]
                     && ctrl_ff[CTRL_REDUCED_FETCH] && !ctrl_ff[CTRL_CHIP_ON_GLASS];
   assign want_reduced = partial_ok && !ctrl_ff[CTRL_FULL_SINGLE] && !ctrl_ff[CTRL_FULL_CONT];

   // decision boundaries count without the guard window
   always_comb
   begin
      decision = 1'b0;
      if (!guard_on_ff && i_line_tick)
      begin
         if (!ctrl_ff[CTRL_VRR_EN])
         begin
            decision = (line_ff >= vmin_ff);
         end
         else if (send_push_ff && line_ff >= flip_ff)
         begin
            decision = 1'b1;
         end
         else
         begin
            decision = (line_ff >= vmax_ff);
         end
      end
   end

   // the frame ends once the guard window has run out after the decision
   // guard count starts at zero on the tick after the decision, so a zero window still ends;
   // at-or-above keeps a window shrunk mid-guard from running the count around
   assign frame_end = guard_on_ff && i_line_tick && (guard_ff >= window_ff);
   assign update_now = frame_end && send_push_ff && push_en_ff;

   // line counter and guard window
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         line_ff <= '0;
         guard_ff <= '0;
         guard_on_ff <= 1'b0;
      end
      else if (frame_end)
      begin
         line_ff <= '0;
         guard_ff <= '0;
         guard_on_ff <= 1'b0;
      end
      else if (i_line_tick)
      begin
         line_ff <= line_ff + RST_ONE;
         if (guard_on_ff)
         begin
            guard_ff <= guard_ff + RST_ONE; // window kept while vblank stretches
         end
         if (decision)
         begin
            guard_on_ff <= 1'b1;
         end
      end
   end

   // delayed vblank: asserts window lines after programmed start
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         vblank_ff <= 1'b0;
      end
      else if (frame_end)
      begin
         vblank_ff <= 1'b0;
      end
      else if (i_line_tick && line_ff >= live_ff.vblank_start + window_ff)
      begin
         vblank_ff <= 1'b1;
      end
   end

   // shadow timing: size and slices at vblank, vblank start/vactive at vtotal
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         live_ff <= '{src_size: '0, slice_rows: '0,
                      vblank_start: RST_VBLANK_START, vactive: RST_VBLANK_START};
      end
      else
      begin
         if (!vblank_ff && i_line_tick && line_ff >= live_ff.vblank_start + window_ff)
         begin
            live_ff.src_size <= pend_ff.src_size;
            live_ff.slice_rows <= pend_ff.slice_rows;
         end
         if (frame_end && (ctrl_ff[CTRL_BUFFERED_VERTICAL_ACTIVE] ? update_now : 1'b1))
         begin
            live_ff.vblank_start <= pend_ff.vblank_start;
            live_ff.vactive <= pend_ff.vactive;
         end
      end
   end

   // push handshake; a new send in the clearing cycle wins
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         push_en_ff <= 1'b0;
         send_push_ff <= 1'b0;
         push_done_ff <= 1'b0;
      end
      else
      begin
         if (i_wr && i_addr == OFS_PUSH)
         begin
            push_en_ff <= i_wdata[PUSH_ENABLE];
            send_push_ff <= i_wdata[PUSH_SEND] && i_wdata[PUSH_ENABLE];
            if (i_wdata[PUSH_SEND])
            begin
               push_done_ff <= 1'b0;
            end
         end
         else if (update_now)
         begin
            send_push_ff <= 1'b0;
            push_done_ff <= 1'b1;
         end
      end
   end

   // bank swap arms regular and reduced sets together; region frozen per frame
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         bank_ff <= 1'b0;
         reduced_ff <= 1'b0;
         frame_region_ff <= '0;
      end
      else if (update_now)
      begin
         bank_ff <= ~bank_ff;
         reduced_ff <= want_reduced;
         frame_region_ff <= region_ff; // last programmed values only
      end
      else if (frame_end && !want_reduced)
      begin
         reduced_ff <= 1'b0; // spontaneous full frames use the regular set
      end
   end

   // metadata packet ahead of active pixels for partial frames
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_due_ff <= 1'b0;
         meta_ff <= 1'b0;
         active_ff <= 1'b0;
         first_ff <= 1'b0;
      end
      else
      begin
         first_ff <= frame_end;
         meta_ff <= 1'b0;
         if (frame_end)
         begin
            meta_due_ff <= update_now && want_reduced;
            active_ff <= 1'b0;
         end
         else if (first_ff && meta_due_ff)
         begin
            meta_ff <= 1'b1;
            meta_due_ff <= 1'b0;
         end
         else if (first_ff || meta_ff)
         begin
            active_ff <= 1'b1; // active data after the packet, or right after first line when none is due
         end
         else if (vblank_ff)
         begin
            active_ff <= 1'b0;
         end
      end
   end

   // software-written configuration; hardware clears single full frame
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_ff <= '0;
         vmin_ff <= RST_VMIN;
         vmax_ff <= RST_VMAX;
         flip_ff <= RST_FLIPLINE;
         window_ff <= '0;
         pend_ff <= '{src_size: '0, slice_rows: '0,
                      vblank_start: RST_VBLANK_START, vactive: RST_VBLANK_START};
         region_ff <= '0;
      end
      else
      begin
         if (frame_end && ctrl_ff[CTRL_FULL_SINGLE] && !(i_wr && i_addr == OFS_CTRL))
         begin
            ctrl_ff[CTRL_FULL_SINGLE] <= 1'b0;
         end
         if (i_wr)
         begin
            case (i_addr)
               OFS_CTRL: ctrl_ff <= i_wdata[CTRL_W-1:0];
               OFS_VMIN: vmin_ff <= i_wdata[LINE_W-1:0];
               OFS_VMAX: vmax_ff <= i_wdata[LINE_W-1:0];
               OFS_FLIPLINE: flip_ff <= i_wdata[LINE_W-1:0];
               OFS_WINDOW: window_ff <= i_wdata[LINE_W-1:0];
               OFS_SRC_SIZE: pend_ff.src_size <= i_wdata[LINE_W-1:0];
               OFS_VBLANK_START: pend_ff.vblank_start <= i_wdata[LINE_W-1:0];
               OFS_VACTIVE: pend_ff.vactive <= i_wdata[LINE_W-1:0];
               OFS_SLICE_ROWS: pend_ff.slice_rows <= i_wdata[LINE_W-1:0];
               OFS_REGION: region_ff <= i_wdata;
               default: ;
            endcase
         end
      end
   end

   // register read, data in the following cycle
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_ff <= WORD_ZERO;
      end
      else if (i_rd)
      begin
         case (i_addr)
            OFS_CTRL: rdata_ff <= {{(32-CTRL_W){1'b0}}, ctrl_ff};
            OFS_PUSH: rdata_ff <= {30'h0, send_push_ff, push_en_ff};
            OFS_STATUS: rdata_ff <= {28'h0, bank_ff, partial_ok, reduced_ff, push_done_ff};
            OFS_VMIN: rdata_ff <= {16'h0, vmin_ff};
            OFS_VMAX: rdata_ff <= {16'h0, vmax_ff};
            OFS_FLIPLINE: rdata_ff <= {16'h0, flip_ff};
            OFS_WINDOW: rdata_ff <= {16'h0, window_ff};
            OFS_SRC_SIZE: rdata_ff <= {16'h0, pend_ff.src_size};
            OFS_VBLANK_START: rdata_ff <= {16'h0, pend_ff.vblank_start};
            OFS_VACTIVE: rdata_ff <= {16'h0, pend_ff.vactive};
            OFS_SLICE_ROWS: rdata_ff <= {16'h0, pend_ff.slice_rows};
            OFS_REGION: rdata_ff <= region_ff;
            default: rdata_ff <= WORD_ZERO;
         endcase
      end
      else
      begin
         rdata_ff <= WORD_ZERO;
      end
   end

   // writes fill the idle bank; fetch reads the armed bank and frame's set
   pfc_regmem #(.AW(MEM_AW), .DW(32)) u_sets (
      .i_clock(i_clock),
      .i_we(plane_wr),
      .i_waddr(ent_addr(~bank_ff, i_addr[7], {2'b00, i_addr[7:2]})),
      .i_wdata(i_wdata),
      .i_raddr(ent_addr(bank_ff, reduced_ff, i_fetch_idx)),
      .o_rdata(o_fetch_data)
   );

   assign o_rdata = rdata_ff;
   assign o_vblank = vblank_ff;
   assign o_first_line = first_ff;
   assign o_meta_valid = meta_ff;
   assign o_meta_region = frame_region_ff;
   assign o_active_en = active_ff;
   assign o_reduced_frame = reduced_ff;
   assign o_timing = live_ff;
endmodule

// >>> tb/pfc_top_monitor.sv
/*
 Port-level assertions for the partial frame fetch controller.
 Assumes a bind into pfc_top, one clock, reset active high.
*/
`timescale 1ns/1ps
module pfc_top_monitor
   import pfc_pkg::*;
#(
   parameter int unsigned PLANES = 4,
   parameter int unsigned REGS_PER_PLANE = 4
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // register port
   input wire logic [pfc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // pipe and fetch
   input wire logic i_line_tick,
   input wire logic [7:0] i_fetch_idx,
   input wire logic [31:0] o_fetch_data,
   // frame outputs
   input wire logic o_vblank,
   input wire logic o_first_line,
   input wire logic o_meta_valid,
   input wire pfc_pkg::pfc_region_t o_meta_region,
   input wire logic o_active_en,
   input wire logic o_reduced_frame,
   input wire pfc_pkg::pfc_timing_t o_timing
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_meta_lead;
      $past(o_first_line) && o_meta_valid && !o_active_en;
   endsequence
   sequence s_active_next;
      ##1 o_active_en;
   endsequence

   a_meta_after_first: assert property (o_meta_valid |-> s_meta_lead)
      else $error("metadata not one cycle after first line");
   a_active_after_meta: assert property (o_meta_valid |-> s_active_next)
      else $error("active pixels not right after metadata");
   a_active_lead: assert property (
      $rose(o_active_en) |-> $past(o_meta_valid) || $past(o_first_line))
      else $error("active pixels without frame lead");
   a_one_region: assert property (o_meta_valid |=> !o_meta_valid [*4])
      else $error("second metadata packet in frame");
   a_vblank_closed: assert property (o_first_line |-> !o_vblank)
      else $error("vblank still high at first line");
   // size and slice rows take effect on the edge that opens vblank
   a_src_latch: assert property (
      $changed(o_timing.src_size) || $changed(o_timing.slice_rows) |-> $rose(o_vblank))
      else $error("source size changed outside vblank");
   a_vact_latch: assert property (
      $changed(o_timing.vblank_start) || $changed(o_timing.vactive) |-> o_first_line)
      else $error("vactive changed outside frame end");
   a_set_switch: assert property ($changed(o_reduced_frame) |-> ##[0:1] o_first_line)
      else $error("register set switched mid frame");
   a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside answer cycle");
endmodule

bind pfc_top pfc_top_monitor #(.PLANES(PLANES), .REGS_PER_PLANE(REGS_PER_PLANE)) mon_u (
   .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_line_tick(i_line_tick), .i_fetch_idx(i_fetch_idx),
   .o_fetch_data(o_fetch_data), .o_vblank(o_vblank), .o_first_line(o_first_line),
   .o_meta_valid(o_meta_valid), .o_meta_region(o_meta_region), .o_active_en(o_active_en),
   .o_reduced_frame(o_reduced_frame), .o_timing(o_timing)
);

// >>> tb/pfc_panel_model.sv
/*
 Panel with remote frame buffer: paces scan lines and records the
 region packets it receives. Assumes the controller's clock.
*/
`timescale 1ns/1ps
module pfc_panel_model
   import pfc_pkg::*;
#(
   parameter int unsigned TICK_DIV = 4
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // from the controller
   input wire logic i_first_line,
   input wire logic i_meta_valid,
   input wire pfc_pkg::pfc_region_t i_meta_region,
   input wire logic i_active_en,
   // line pacing and observations
   output logic o_line_tick,
   output logic [7:0] o_meta_count,
   output pfc_pkg::pfc_region_t o_last_region,
   output logic o_order_err
);
   logic [7:0] div_ff;
   logic seen_ff;

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         div_ff <= 8'h0;
         o_line_tick <= 1'b0;
      end
      else
      begin
         div_ff <= (div_ff == 8'(TICK_DIV - 1)) ? 8'h0 : div_ff + 8'h1;
         o_line_tick <= (div_ff == 8'h0);
      end
   end

   // panel can only place pixels once it knows the band
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         seen_ff <= 1'b0;
         o_meta_count <= 8'h0;
         o_last_region <= '0;
         o_order_err <= 1'b0;
      end
      else if (i_first_line)
         seen_ff <= 1'b0;
      else if (i_meta_valid)
      begin
         seen_ff <= 1'b1;
         o_meta_count <= o_meta_count + 8'h1;
         o_last_region <= i_meta_region;
         if (seen_ff || i_active_en)
            o_order_err <= 1'b1;
      end
   end
endmodule

// >>> tb/tb_top.sv
/*
 Self-checking bench for the partial frame fetch controller.
 Assumes the panel model paces lines every TICK_DIV cycles.
*/
`timescale 1ns/1ps
module tb_top;
   import pfc_pkg::*;
   localparam int TICK_DIV = 4;
   localparam int LIMIT = 30000;
   logic i_clock, i_rst, i_wr, i_rd, i_line_tick, o_vblank, o_first_line, o_meta_valid;
   logic o_active_en, o_reduced_frame, order_err;
   logic [ADDR_W-1:0] i_addr;
   logic [31:0] i_wdata, o_rdata, o_fetch_data, rv;
   logic [7:0] i_fetch_idx, meta_count;
   pfc_region_t o_meta_region, last_region;
   pfc_timing_t o_timing;
   logic [ADDR_W-1:0] ra [6] = '{OFS_VMIN, OFS_VMAX, OFS_FLIPLINE, OFS_STATUS, 12'h0fc, 12'h100};
   logic [31:0] re [6] = '{{16'h0, RST_VMIN}, {16'h0, RST_VMAX}, {16'h0, RST_FLIPLINE},
      32'h0, 32'h0, 32'h0};
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int t0, p0;

   pfc_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line_tick(i_line_tick),
      .i_fetch_idx(i_fetch_idx), .o_fetch_data(o_fetch_data), .o_vblank(o_vblank),
      .o_first_line(o_first_line), .o_meta_valid(o_meta_valid), .o_meta_region(o_meta_region),
      .o_active_en(o_active_en), .o_reduced_frame(o_reduced_frame), .o_timing(o_timing));
   pfc_panel_model #(.TICK_DIV(TICK_DIV)) panel_u (.i_clock(i_clock), .i_rst(i_rst),
      .i_first_line(o_first_line), .i_meta_valid(o_meta_valid), .i_meta_region(o_meta_region),
      .i_active_en(o_active_en), .o_line_tick(i_line_tick), .o_meta_count(meta_count),
      .o_last_region(last_region), .o_order_err(order_err));

   initial
   begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   task automatic test_done();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fails++;
         $display("[FAIL] %0t run did not finish", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      @(negedge i_clock);
      d = o_rdata;
   endtask

   task automatic wait_first();
      int n;
      n = 0;
      do
      begin
         @(negedge i_clock);
         n++;
      end while (o_first_line !== 1'b1 && n < 3000);
   endtask

   // push done only shows after the frame end, so poll with a bound
   task automatic flip(input logic [31:0] ctrl);
      int n;
      n = 0;
      wr(OFS_CTRL, ctrl);
      wr(OFS_PUSH, 32'h3);
      rv = 32'h0;
      while (rv[STAT_PUSH_DONE] !== 1'b1 && n < 400)
      begin
         rd(OFS_STATUS, rv);
         n++;
      end
      chk({31'h0, rv[STAT_PUSH_DONE]}, 32'h1, "push done");
      repeat (4) @(negedge i_clock);
   endtask

   initial
   begin
      i_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      i_fetch_idx = 8'h0;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      chk({16'h0, o_timing.vactive}, {16'h0, RST_VBLANK_START}, "vactive reset");
      for (int i = 0; i < 6; i++)
      begin
         rd(ra[i], rv);
         chk(rv, re[i], "reset or unmapped read");
      end
      $display("test reset done");

      wr(OFS_VMIN, 32'h10);
      wr(OFS_WINDOW, 32'h0);
      wait_first();
      wait_first();
      t0 = cycles;
      wait_first();
      p0 = cycles - t0;
      wr(OFS_WINDOW, 32'h4);
      wait_first();
      wait_first();
      t0 = cycles;
      wait_first();
      chk(32'(cycles - t0 - p0), 32'(4 * TICK_DIV), "guard window frame stretch");
      $display("test guard window done");

      wr(OFS_PUSH, 32'h1);
      wr(OFS_CTRL, 32'h80);
      wr(OFS_CTRL, 32'h81);
      wr(OFS_VMAX, 32'd36);
      wr(OFS_FLIPLINE, 32'd20);
      wr(OFS_CTRL, 32'h9f);
      rd(OFS_STATUS, rv);
      chk({31'h0, rv[STAT_PARTIAL_OK]}, 32'h0, "partial with chip on glass");
      wr(OFS_CTRL, 32'h8f);
      rd(OFS_STATUS, rv);
      chk({31'h0, rv[STAT_PARTIAL_OK]}, 32'h1, "partial allowed");
      wait_first();
      wr(OFS_SRC_SIZE, 32'h40);
      wr(OFS_SLICE_ROWS, 32'h4);
      wr(OFS_VBLANK_START, 32'h0c);
      wr(OFS_VACTIVE, 32'h20);
      wr(OFS_REGION, 32'h0004_000b);
      wr(OFS_REGION, 32'h0004_0017);
      wr(12'h100, 32'ha1a1_0001);
      wr(12'h180, 32'hb1b1_0001);
      chk({16'h0, o_timing.src_size}, 32'h0, "source size not yet live");
      flip(32'h8f);
      chk({24'h0, meta_count}, 32'h1, "one metadata packet");
      chk(last_region, 32'h0004_0017, "last programmed region");
      chk({31'h0, order_err}, 32'h0, "metadata ahead of pixels");
      chk({o_timing.vblank_start, o_timing.vactive}, 32'h000c_0020, "vactive latched");
      chk({31'h0, o_reduced_frame}, 32'h1, "reduced frame");
      chk(o_fetch_data, 32'hb1b1_0001, "reduced set fetched");
      // source size only moves at the next vblank, one frame after the push
      wait_first();
      chk({o_timing.src_size, o_timing.slice_rows}, 32'h0040_0004, "size latched");
      chk({31'h0, o_vblank}, 32'h0, "vblank closed at first line");
      $display("test partial update done");

      wait_first();
      wr(12'h100, 32'ha2a2_0002);
      wr(12'h180, 32'hb2b2_0002);
      chk(o_fetch_data, 32'hb1b1_0001, "idle set not live");
      flip(32'haf);
      chk({31'h0, o_reduced_frame}, 32'h0, "full frame");
      chk(o_fetch_data, 32'ha2a2_0002, "regular set fetched");
      $display("test full frame done");
      test_done();
   end
endmodule
